// ---- pee_host.sv ----
// Host controller driving a byte-wide parallel EEPROM over its pins
//
// Operation
// - Reads assert chip select and output drive together.
// - Writes hold output drive high with chip select and write strobe low.
// - Further page bytes keep address bits 14..7 of the first byte.
// - A write not marked last may continue as a page with one to 127 more bytes.
// - Each next write strobe falls within 100 us of the previous.
`timescale 1ns/1ps
`include "pee_cfg.svh"
module pee_host
    import pee_pkg::*;
#(
    parameter logic [`PEE_CNT_W-1:0] LOAD_WIN_CYC = `PEE_CNT_W'(`PEE_LOAD_WIN)
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // Command port
    input  wire logic                    cmd_valid,
    input  wire pee_cmd_s                cmd,
    output logic                         cmd_ready,
    input  wire logic                    poll_toggle,
    // Answer port
    output logic                         rsp_valid,
    output pee_rsp_s                     rsp,
    output logic                         busy,
    // Device pins
    output pee_pins_s                    pins,
    input  wire logic [`PEE_DATA_W-1:0]  data_bus_i
);
    pee_state_e                st_q, st_d;
    logic [`PEE_CNT_W-1:0]     cnt_q, cnt_d, win_q, win_d;
    logic [7:0]                nbyte_q, nbyte_d;
    pee_pins_s                 pins_q, pins_d;
    pee_cmd_s                  last_q, last_d, pendc_q, pendc_d;
    logic                      pend_q, pend_d, first_q, first_d;
    logic                      tgl_q, tgl_d, mode_q, mode_d;
    logic                      rspv_q, rspv_d, ready_q, ready_d;
    pee_rsp_s                  rsp_q, rsp_d;
    logic [`PEE_DATA_W-1:0]    sync1_q, sync2_q;

    // Command source, page match and timing decode
    pee_cmd_s  csel;
    logic      take, start, same_page, win_out, smp, wp_end, page_full;
    logic      poll_done, prog_on;
    assign take      = cmd_valid & ready_q;
    assign csel      = pend_q ? pendc_q : cmd;
    assign start     = pend_q | take;
    assign same_page = cmd.write & (cmd.addr[`PEE_ADDR_W-1:`PEE_PAGE_LSB] ==
                       last_q.addr[`PEE_ADDR_W-1:`PEE_PAGE_LSB]);
    assign win_out   = win_q >= LOAD_WIN_CYC;
    assign smp       = cnt_q == `PEE_CNT_W'(`PEE_RD_SMP - 1);
    assign wp_end    = cnt_q == `PEE_CNT_W'(`PEE_WP_CYC - 1);
    assign page_full = nbyte_q == 8'(`PEE_PAGE_BYTES);
    // Polls count only once the device must have begun programming,
    // so reads still inside its load window cannot end the wait early
    assign prog_on   = win_q >= LOAD_WIN_CYC +
                       `PEE_CNT_W'(2 * `PEE_WIN_MARGIN);
    // Data polling compares bit 7, toggle polling compares two reads of bit 6
    assign poll_done = prog_on && (mode_q ? (!first_q &&
                       sync2_q[`PEE_TGL_BIT] == tgl_q)
                     : (sync2_q[`PEE_POLL_BIT] ==
                        last_q.data[`PEE_POLL_BIT]));

    // Next state and pin levels
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q + `PEE_CNT_W'(1);
        win_d   = (win_q == '1) ? win_q : win_q + `PEE_CNT_W'(1);
        nbyte_d = nbyte_q;
        pins_d  = pins_q;
        last_d  = last_q;
        pendc_d = pendc_q;
        pend_d  = pend_q;
        first_d = first_q;
        tgl_d   = tgl_q;
        mode_d  = mode_q;
        rspv_d  = 1'b0;
        rsp_d   = rsp_q;
        case (st_q)
            PEE_IDLE: begin
                if (start) begin
                    pend_d = 1'b0;
                    cnt_d  = '0;
                    pins_d.byte_address = csel.addr;
                    if (csel.write) begin
                        last_d  = csel;
                        nbyte_d = 8'h00;
                        pins_d.data_bus_o = csel.data;
                        st_d = PEE_WR_SET;
                    end else begin
                        pins_d.ce_n = 1'b0;
                        pins_d.oe_n = 1'b0;
                        st_d = PEE_RD;
                    end
                end
            end
            PEE_RD: begin
                if (smp) begin
                    rsp_d  = '{write: 1'b0, data: sync2_q};
                    rspv_d = 1'b1;
                    pins_d.ce_n = 1'b1;
                    pins_d.oe_n = 1'b1;
                    st_d = PEE_RD_END;
                end
            end
            PEE_RD_END: st_d = PEE_IDLE;
            PEE_WR_SET: begin
                pins_d.ce_n = 1'b0;
                pins_d.oe_n = 1'b1;
                pins_d.data_bus_oe = 1'b1;
                cnt_d = '0;
                st_d  = PEE_WR_PULSE;
            end
            PEE_WR_PULSE: begin
                if (pins_q.we_n) begin
                    pins_d.we_n = 1'b0;
                    win_d   = '0;
                    nbyte_d = nbyte_q + 8'h01;
                    cnt_d   = '0;
                end else if (wp_end) begin
                    pins_d.we_n = 1'b1;
                    st_d = PEE_WR_HOLD;
                end
            end
            PEE_WR_HOLD: begin
                pins_d.ce_n = 1'b1;
                pins_d.data_bus_oe = 1'b0;
                st_d = PEE_WR_END;
            end
            PEE_WR_END: begin
                mode_d  = poll_toggle;
                first_d = 1'b1;
                st_d = (last_q.last || page_full) ? PEE_POLL_END
                                                  : PEE_LOAD_WIN;
            end
            PEE_LOAD_WIN: begin
                if (take && same_page && !win_out) begin
                    last_d = cmd;
                    pins_d.byte_address = cmd.addr;
                    pins_d.data_bus_o   = cmd.data;
                    st_d = PEE_WR_SET;
                end else if (take) begin
                    pend_d  = 1'b1;
                    pendc_d = cmd;
                    st_d = PEE_POLL_END;
                end else if (win_out) begin
                    st_d = PEE_POLL_END;
                end
            end
            PEE_POLL: begin
                if (smp) begin
                    pins_d.ce_n = 1'b1;
                    pins_d.oe_n = 1'b1;
                    first_d = !prog_on;
                    tgl_d   = sync2_q[`PEE_TGL_BIT];
                    if (poll_done) begin
                        rsp_d  = '{write: 1'b1, data: sync2_q};
                        rspv_d = 1'b1;
                        st_d = PEE_RD_END;
                    end else begin
                        st_d = PEE_POLL_END;
                    end
                end
            end
            PEE_POLL_END: begin
                pins_d.byte_address = last_q.addr;
                pins_d.ce_n = 1'b0;
                pins_d.oe_n = 1'b0;
                cnt_d = '0;
                st_d  = PEE_POLL;
            end
            default: st_d = PEE_IDLE;
        endcase
        ready_d = !pend_d && (st_d == PEE_IDLE || st_d == PEE_LOAD_WIN);
    end

    // Two-stage synchroniser for the device data bus
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= data_bus_i;
            sync2_q <= sync1_q;
        end
    end

    // Sequencer state and pin registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q    <= PEE_IDLE;
            cnt_q   <= '0;
            win_q   <= '0;
            nbyte_q <= 8'h00;
            pins_q  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            win_q   <= win_d;
            nbyte_q <= nbyte_d;
            pins_q  <= pins_d;
        end
    end

    // Page, polling and answer registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_q  <= '0;
            pendc_q <= '0;
            pend_q  <= 1'b0;
            first_q <= 1'b1;
            tgl_q   <= 1'b0;
            mode_q  <= 1'b0;
            rspv_q  <= 1'b0;
            rsp_q   <= '0;
            ready_q <= 1'b0;
        end else begin
            last_q  <= last_d;
            pendc_q <= pendc_d;
            pend_q  <= pend_d;
            first_q <= first_d;
            tgl_q   <= tgl_d;
            mode_q  <= mode_d;
            rspv_q  <= rspv_d;
            rsp_q   <= rsp_d;
            ready_q <= ready_d;
        end
    end

    // Busy flag follows the registered state
    logic busy_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) busy_q <= 1'b0;
        else       busy_q <= (st_d != PEE_IDLE) || pend_d;
    end

    assign pins      = pins_q;
    assign cmd_ready = ready_q;
    assign rsp_valid = rspv_q;
    assign rsp       = rsp_q;
    assign busy      = busy_q;
endmodule // pee_host

// ---- pee_cfg.svh ----
// Pin timing, field positions and sizes for the parallel EEPROM host
`ifndef PEE_CFG_SVH
`define PEE_CFG_SVH
`define PEE_ADDR_W      15
`define PEE_DATA_W      8
`define PEE_PAGE_LSB    7
`define PEE_PAGE_BYTES  128
`define PEE_POLL_BIT    7
`define PEE_TGL_BIT     6
`define PEE_CNT_W       16
`define PEE_CLK_NS      10
`define PEE_T_ACC_NS    70
`define PEE_T_WP_NS     100
`define PEE_T_BLC_US    100
`define PEE_SYNC_CYC    2
`define PEE_WIN_MARGIN  16
`define PEE_RD_CYC      ((`PEE_T_ACC_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_RD_SMP      (`PEE_RD_CYC + `PEE_SYNC_CYC)
`define PEE_WP_CYC      ((`PEE_T_WP_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_BLC_CYC     ((`PEE_T_BLC_US * 1000) / `PEE_CLK_NS)
`define PEE_LOAD_WIN    (`PEE_BLC_CYC - `PEE_WIN_MARGIN)
`endif

// ---- pee_pkg.sv ----
// Types shared by the parallel EEPROM host controller
`include "pee_cfg.svh"
package pee_pkg;
    typedef enum logic [3:0] {
        PEE_IDLE, PEE_RD, PEE_RD_END, PEE_WR_SET, PEE_WR_PULSE,
        PEE_WR_HOLD, PEE_WR_END, PEE_LOAD_WIN, PEE_POLL, PEE_POLL_END
    } pee_state_e;

    typedef struct packed {
        logic                     write;
        logic                     last;
        logic [`PEE_ADDR_W-1:0]   addr;
        logic [`PEE_DATA_W-1:0]   data;
    } pee_cmd_s;

    typedef struct packed {
        logic                     write;
        logic [`PEE_DATA_W-1:0]   data;
    } pee_rsp_s;

    typedef struct packed {
        logic                     ce_n;
        logic                     oe_n;
        logic                     we_n;
        logic                     data_bus_oe;
        logic [`PEE_DATA_W-1:0]   data_bus_o;
        logic [`PEE_ADDR_W-1:0]   byte_address;
    } pee_pins_s;
endpackage

// ---- pee_eeprom_model.sv ----
// Behavioural model of the byte-wide parallel EEPROM on the host pins
`timescale 1ns/1ps
module pee_eeprom_model #(
    parameter int BLC_NS  = 410,
    parameter int PROG_NS = 3000
) (
    // Device pins
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [14:0] byte_address,
    input  wire logic [7:0]  data_in,
    // Read drive towards the shared bus
    output logic [7:0]       data_out,
    output logic             drive
);
    logic [7:0]   mem [0:32767];
    logic [7:0]   pbuf [0:127];
    logic [127:0] vm = '0;
    logic [14:0]  a_q = '0;
    logic [7:0]   pg = '0;
    logic [7:0]   ld = '0;
    logic         prog = 1'b0;
    logic         tgl = 1'b0;
    int           n = 0;
    realtime      t_we = 0;
    // Known levels only, so unknown pins before reset give no false edge
    wire          wr = (ce_n === 1'b0) && (we_n === 1'b0)
                       && (oe_n === 1'b1);
    // Known contents so reads before any write are predictable
    initial for (int i = 0; i < 32768; i++) mem[i] = i[7:0] ^ 8'h5A;
    // Address on the later falling edge, ignored while programming
    always @(posedge wr) if (!prog) begin
        a_q = byte_address;
        t_we = $realtime;
    end
    // Data on the earlier rising edge into the page buffer
    always @(negedge wr) if (!prog && n < 128) begin
        pbuf[a_q[6:0]] = data_in;
        vm[a_q[6:0]] = 1'b1;
        pg = a_q[14:7];
        ld = data_in;
        n++;
    end
    // Self-timed programming after the byte load window lapses
    always begin
        #10;
        if (n > 0 && $realtime - t_we >= BLC_NS) begin
            prog = 1'b1;
            #PROG_NS;
            for (int i = 0; i < 128; i++)
                if (vm[i]) mem[{pg, i[6:0]}] = pbuf[i];
            vm = '0;
            n = 0;
            prog = 1'b0;
        end
    end
    // Status bit flips on each read attempt while programming
    always @(negedge (ce_n | oe_n)) if (prog) tgl = ~tgl;
    // Drive only while selected and enabled; status bits while busy
    assign drive = (ce_n === 1'b0) && (oe_n === 1'b0);
    assign data_out = prog ? {~ld[7], tgl, mem[byte_address][5:0]}
                           : mem[byte_address];
endmodule // pee_eeprom_model

// ---- pee_host_properties.sv ----
// Concurrent checks on the parallel EEPROM host ports
`timescale 1ns/1ps
`include "pee_cfg.svh"
module pee_host_properties
    import pee_pkg::*;
#(
    parameter logic [`PEE_CNT_W-1:0] LOAD_WIN_CYC = `PEE_CNT_W'(`PEE_LOAD_WIN)
) (
    // Clock and reset
    input wire logic      clk,
    input wire logic      rstn,
    // Host side
    input wire logic      cmd_valid,
    input wire pee_cmd_s  cmd,
    input wire logic      cmd_ready,
    input wire logic      rsp_valid,
    input wire pee_rsp_s  rsp,
    // Device pins
    input wire pee_pins_s pins
);
    logic        we_q;
    logic        open_q;
    logic [15:0] gap_q;
    logic [7:0]  nb_q;
    logic [7:0]  pg_q;
    wire         fall = we_q && !pins.we_n;
    // Page load tracking: strobe spacing, byte count, page
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            we_q <= 1'b1;
            open_q <= 1'b0;
            gap_q <= 16'h0000;
            nb_q <= 8'h00;
            pg_q <= 8'h00;
        end else begin
            we_q <= pins.we_n;
            open_q <= !pins.oe_n ? 1'b0 : (fall | open_q);
            gap_q <= fall ? 16'h0000 : gap_q + {15'h0000, ~&gap_q};
            nb_q <= !pins.oe_n ? 8'h00 : nb_q + {7'h00, fall};
            if (fall) pg_q <= pins.byte_address[14:7];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_rd_walk;
        cmd_valid && cmd_ready && !open_q && !cmd.write |=>
            (!pins.ce_n && !pins.oe_n)[*8] ##2
            (rsp_valid && pins.ce_n && pins.oe_n);
    endproperty
    property p_bus_free;
        !pins.oe_n |-> !pins.data_bus_oe && pins.we_n;
    endproperty
    property p_ce_idle; pins.ce_n |-> pins.oe_n && pins.we_n; endproperty
    property p_wr_ce; fall |-> !$past(pins.ce_n) && pins.oe_n; endproperty
    property p_wr_hold;
        !pins.we_n |-> pins.data_bus_oe && $stable(pins.data_bus_o)
            && $stable(pins.byte_address);
    endproperty
    property p_we_rise;
        $rose(pins.we_n) |-> !pins.ce_n && pins.data_bus_oe;
    endproperty
    property p_wp_width;
        fall |-> (!pins.we_n)[*8] ##2 !pins.we_n ##1 pins.we_n;
    endproperty
    property p_spacing;
        fall && open_q |-> gap_q < LOAD_WIN_CYC + 16'h0010;
    endproperty
    property p_page;
        fall && open_q |-> pins.byte_address[14:7] == pg_q;
    endproperty
    property p_count; fall && open_q |-> nb_q < 8'h80; endproperty
    a_rd_walk: assert property (p_rd_walk) else $error("read walk");
    a_bus_free: assert property (p_bus_free) else $error("bus clash");
    a_ce_idle: assert property (p_ce_idle) else $error("standby");
    a_wr_ce: assert property (p_wr_ce) else $error("write select");
    a_wr_hold: assert property (p_wr_hold) else $error("write hold");
    a_we_rise: assert property (p_we_rise) else $error("data latch");
    a_wp_width: assert property (p_wp_width) else $error("strobe");
    a_spacing: assert property (p_spacing) else $error("load gap");
    a_page: assert property (p_page) else $error("page change");
    a_count: assert property (p_count) else $error("page size");
    c_read: cover property (cmd_valid && cmd_ready && !cmd.write);
    c_page: cover property (fall && open_q);
    c_done: cover property (rsp_valid && rsp.write);
endmodule // pee_host_properties
bind pee_host pee_host_properties #(.LOAD_WIN_CYC(LOAD_WIN_CYC)) u_props (
    .clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins));

// ---- pee_host_tb.sv ----
// Self-checking testbench for the parallel EEPROM host
`timescale 1ns/1ps
module pee_host_tb;
    import pee_pkg::*;
    logic      clk = 1'b0;
    logic      rstn = 1'b0;
    logic      cmd_valid = 1'b0;
    logic      poll_toggle = 1'b0;
    pee_cmd_s  cmd = '0;
    logic      cmd_ready, rsp_valid, busy, drv;
    pee_rsp_s  rsp;
    pee_pins_s pins;
    logic [7:0] bus, dout;
    logic [7:0] bus_q = 8'h00;
    int        failures = 0;
    int        n_compared = 0;
    always #5 clk = ~clk;
    // Undriven bus shows a pattern that changes every cycle
    always @(posedge clk) bus_q <= bus;
    assign bus = pins.data_bus_oe ? pins.data_bus_o : drv ? dout : ~bus_q;
    pee_host #(.LOAD_WIN_CYC(16'h0028)) uut (.clk(clk), .rstn(rstn),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .poll_toggle(poll_toggle), .rsp_valid(rsp_valid), .rsp(rsp),
        .busy(busy), .pins(pins), .data_bus_i(bus));
    pee_eeprom_model #(.BLC_NS(410), .PROG_NS(3000)) u_dev (.ce_n(pins.ce_n),
        .oe_n(pins.oe_n), .we_n(pins.we_n), .byte_address(pins.byte_address),
        .data_in(bus), .data_out(dout), .drive(drv));
    task automatic conclude;
        if (failures == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Offer one command and hold it until taken
    task automatic send(logic w, logic l, logic [14:0] a, logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{write: w, last: l, addr: a, data: d};
        do begin @(posedge clk); n++; end while (cmd_ready !== 1'b1 && n < 50);
        cmd_valid <= 1'b0;
        if (n >= 50) begin failures++; conclude(); end
    endtask
    // Wait for the next answer, counting cycles
    task automatic get(output pee_rsp_s r, output int n);
        n = 0;
        do begin @(posedge clk); n++; end while (rsp_valid !== 1'b1 && n < 5000);
        if (n >= 5000) begin failures++; conclude(); end
        r = rsp;
    endtask
    task automatic rd_chk(logic [14:0] a, logic [7:0] e);
        pee_rsp_s r;
        int n;
        send(1'b0, 1'b0, a, 8'h00);
        get(r, n);
        check("read_data", r.data, e);
    endtask
    // Read of untouched top location
    task automatic t_read;
        rd_chk(15'h7FFF, 8'hA5);
    endtask
    // Single byte with bit 7 polling; old bit 7 differs from new
    task automatic t_byte;
        pee_rsp_s r;
        int n;
        poll_toggle <= 1'b0;
        send(1'b1, 1'b1, 15'h0123, 8'hBC);
        get(r, n);
        check("done_kind", r.write, 1'b1);
        check("done_late", n >= 300, 1'b1);
        check("done_data", r.data, 8'hBC);
        rd_chk(15'h0123, 8'hBC);
    endtask
    // Three byte page closed by window lapse, bit 6 polling
    task automatic t_page;
        pee_rsp_s r;
        int n;
        poll_toggle <= 1'b1;
        send(1'b1, 1'b0, 15'h0250, 8'h11);
        send(1'b1, 1'b0, 15'h0251, 8'h22);
        send(1'b1, 1'b0, 15'h0252, 8'h33);
        get(r, n);
        check("page_done", r.write, 1'b1);
        check("page_late", n >= 300, 1'b1);
        rd_chk(15'h0250, 8'h11);
        rd_chk(15'h0252, 8'h33);
        rd_chk(15'h0253, 8'h09);
    endtask
    // Read offered in the load window waits until programming is done
    task automatic t_pend;
        pee_rsp_s r;
        int n;
        poll_toggle <= 1'b0;
        send(1'b1, 1'b0, 15'h0400, 8'h80);
        send(1'b0, 1'b0, 15'h0401, 8'h00);
        get(r, n);
        check("pend_first", r.write, 1'b1);
        check("pend_late", n >= 300, 1'b1);
        get(r, n);
        check("pend_kind", r.write, 1'b0);
        check("pend_data", r.data, 8'h5B);
        @(posedge clk);
        check("end_busy", busy, 1'b0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        check("idle_busy", busy, 1'b0);
        check("idle_ready", cmd_ready, 1'b1);
        check("idle_ce", pins.ce_n, 1'b1);
        t_read();
        t_byte();
        t_page();
        t_pend();
        conclude();
    end
endmodule // pee_host_tb
